// File: qpc_consts.svh
/*
  Shared constants of the 24-bit pulse counter: count width and limits,
  status codes, accepted multiplication factors and reset values.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef QPC_CONSTS_SVH
`define QPC_CONSTS_SVH

`define QPC_CNT_W 24
`define QPC_CNT_MAX 24'hffffff
`define QPC_CNT_RST 24'h000000
`define QPC_PRESET_VALUE_LIMIT 32'h00ffffff

`define QPC_STAT_OK 8'h00
`define QPC_STAT_EDGE_MULTIPLICATION_FACTOR 8'h02
`define QPC_STAT_RANGE 8'h03
`define QPC_STAT_DISABLED 8'h04

`define QPC_EDGE_MULTIPLICATION_FACTOR_ONE 8'h01
`define QPC_EDGE_MULTIPLICATION_FACTOR_TWO 8'h02
`define QPC_EDGE_MULTIPLICATION_FACTOR_FOUR 8'h04

`define QPC_SYNC_RST 1'b0

`endif

// File: qpc_pkg.sv
/*
  Types of the 24-bit pulse counter.
  Assumes qpc_consts.svh is on the include path.
*/
`include "qpc_consts.svh"

package qpc_pkg;
  typedef logic [`QPC_CNT_W-1:0] qpc_count_t;
  typedef logic [7:0] qpc_stat_t;
  typedef logic [7:0] qpc_edge_multiplication_factor_code_t;
  typedef enum logic [1:0] {QPC_X1, QPC_X2, QPC_X4} qpc_edge_multiplication_factor_t;
endpackage

// File: qpc_pin_sync.sv
/*
  Two-stage synchroniser with edge detection for the counter's pin inputs.
  Assumes pins are asynchronous to the system clock; edges are reported
  in the same cycle as the level reaches the second stage.
*/
`timescale 1ns/1ps
`include "qpc_consts.svh"

module qpc_pin_sync #(
  parameter int W = 3
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Pins and synchronised views
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import qpc_pkg::*;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      logic last_ff;
      logic nxt_meta;
      logic nxt_sync;
      logic nxt_last;

      always_comb begin
        nxt_meta = ce ? pin_in[gi] : meta_ff;
        nxt_sync = ce ? meta_ff : sync_ff;
        nxt_last = ce ? sync_ff : last_ff;
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_ff <= `QPC_SYNC_RST;
          sync_ff <= `QPC_SYNC_RST;
          last_ff <= `QPC_SYNC_RST;
        end else begin
          meta_ff <= nxt_meta;
          sync_ff <= nxt_sync;
          last_ff <= nxt_last;
        end
      end

      assign level[gi] = sync_ff;
      assign rise[gi] = sync_ff & ~last_ff;
      assign fall[gi] = ~sync_ff & last_ff;
    end
  endgenerate
endmodule

// File: qpc_step_decode.sv
/*
  Turns synchronised phase edges into one-cycle count steps with a direction.
  Assumes edges come from qpc_pin_sync on the same clock.
*/
`timescale 1ns/1ps

module qpc_step_decode (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Synchronised phases
  input wire logic a_lvl,
  input wire logic b_lvl,
  input wire logic a_rise,
  input wire logic a_fall,
  input wire logic b_rise,
  input wire logic b_fall,
  // Mode
  input wire logic two_phase,
  input wire qpc_pkg::qpc_edge_multiplication_factor_t edge_multiplication_factor,
  input wire logic dir_from_b,
  input wire logic down_sel,
  // Step out
  output logic step,
  output logic up
);
  import qpc_pkg::*;

  logic step_ff;
  logic up_ff;
  logic nxt_step;
  logic nxt_up;
  logic a_edge;
  logic b_edge;

  always_comb begin
    a_edge = a_rise | a_fall;
    b_edge = b_rise | b_fall;
    nxt_step = 1'b0;
    nxt_up = up_ff;
    if (!two_phase) begin
      // Single phase counts A rising edges only; multiplication is ignored.
      nxt_step = a_rise;                                     // [R8]
      nxt_up = dir_from_b ? b_lvl : ~down_sel;               // [R3] [R5]
    end else begin
      // Direction follows which phase leads; direction controls are ignored.
      case (edge_multiplication_factor)                                            // [R9] [R19]
        QPC_X1: begin
          nxt_step = a_rise;
          nxt_up = ~b_lvl;                                   // [R20]
        end
        QPC_X2: begin
          nxt_step = a_edge;
          nxt_up = a_lvl ^ b_lvl;                            // [R20]
        end
        QPC_X4: begin
          nxt_step = a_edge | b_edge;
          nxt_up = a_edge ? (a_lvl ^ b_lvl) : ~(a_lvl ^ b_lvl);  // [R20]
        end
        default: begin
          nxt_step = 1'b0;
          nxt_up = up_ff;
        end
      endcase
    end
    if (!ce) begin
      nxt_step = step_ff;
      nxt_up = up_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_ff <= 1'b0;
      up_ff <= 1'b1;
    end else begin
      step_ff <= nxt_step;
      up_ff <= nxt_up;
    end
  end

  assign step = step_ff;
  assign up = up_ff;
endmodule

// File: qpc_counter_top.sv
/*
  Top of the 24-bit pulse counter: configure, read and preset request ports,
  phase and preset pins, count and carry state, and status answers.
  Assumes request strobes come from logic on CLK_SYS and pins are asynchronous.
*/
// Functional notes
// [R1] Phase mode 0 single-phase, 1 two-phase.
// [R2] Two-phase multiplication accepts only 1, 2, 4.
// [R3] Single-phase direction from program bit or B.
// [R4] Carry clear input set clears carry flag.
// [R5] Program direction: down bit 0 up, 1 down.
// [R6] Pulses counted only while enable bit is 1.
// [R7] Preset source: 0 program, 1 external pin.
// [R8] Single-phase mode ignores multiplication factor.
// [R9] Two-phase ignores direction source and down bit.
// [R10] Disabled counter holds count at zero.
// [R11] Read returns count, range 0 to 16777215.
// [R12] Read also returns the carry flag.
// [R13] Requester keeps preset value within 24 bits.
// [R14] Program preset loads on request rising edge.
// [R15] External preset loads on pin rising edge.
// [R16] Carry forced off while preset executes.
// [R17] No preset performed while counter disabled.
// [R18] Successful request gives done and status code.
// [R19] Two-phase edges: x1 A rise, x2 A, x4 both.
// [R20] Two-phase direction from A/B phase relation.
// [R21] Bad multiplication factor reports status 02.
// [R22] Preset while disabled reports status 04.
// [R23] Up-count past maximum wraps, sets carry.
`timescale 1ns/1ps
`include "qpc_consts.svh"

module qpc_counter_top (
  // Clock, reset and enable
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Pulse generator pins
  input wire logic PHASE_A,
  input wire logic PHASE_B,
  input wire logic PRESET_PIN,
  // Configure request
  input wire logic COUNTER_CONFIGURE_REQUEST,
  input wire logic PHASE_MODE_SELECT,
  input wire qpc_pkg::qpc_edge_multiplication_factor_code_t EDGE_MULTIPLICATION_FACTOR,
  input wire logic DIR_SOURCE_SELECT,
  input wire logic CARRY_CLEAR,
  input wire logic DOWN_SELECT,
  input wire logic COUNTER_ENABLE_BIT,
  input wire logic PRESET_SOURCE_SELECT,
  output logic CFG_DONE,
  output qpc_pkg::qpc_stat_t CFG_STAT,
  // Read request
  input wire logic COUNTER_READ_REQUEST,
  output logic RD_DONE,
  output qpc_pkg::qpc_stat_t RD_STAT,
  output qpc_pkg::qpc_count_t CURRENT_COUNT,
  output logic CARRY_FLAG,
  // Preset request
  input wire logic COUNTER_PRESET_REQUEST,
  input wire logic [31:0] PRESET_VALUE,
  output logic PRE_DONE,
  output qpc_pkg::qpc_stat_t PRE_STAT
);
  import qpc_pkg::*;

  // Pin synchronisation and step decoding.
  logic [2:0] pin_level, pin_rise, pin_fall;
  logic step, step_up;

  // Request edge detection.
  logic cfg_req_d_ff, rd_req_d_ff, pre_req_d_ff;
  logic nxt_cfg_req_d, nxt_rd_req_d, nxt_pre_req_d;
  logic cfg_edge, rd_edge, pre_edge;

  // Configuration.
  logic phase_mode_ff, dir_src_ff, down_ff, enable_ff, pre_src_ff;
  logic nxt_phase_mode, nxt_dir_src, nxt_down, nxt_enable, nxt_pre_src;
  qpc_edge_multiplication_factor_t edge_multiplication_factor_ff, nxt_edge_multiplication_factor, edge_multiplication_factor_dec;
  logic edge_multiplication_factor_ok, cfg_accept;

  // Count state.
  qpc_count_t count_ff, preset_ff, nxt_count, nxt_preset;
  logic carry_ff, nxt_carry, preset_value_in_range, prog_load, ext_load, wrap_up;

  // Answers.
  logic cfg_done_ff, rd_done_ff, rd_carry_ff, pre_done_ff;
  logic nxt_cfg_done, nxt_rd_done, nxt_rd_carry, nxt_pre_done;
  qpc_stat_t cfg_stat_ff, rd_stat_ff, pre_stat_ff;
  qpc_stat_t nxt_cfg_stat, nxt_rd_stat, nxt_pre_stat;
  qpc_count_t rd_count_ff, nxt_rd_count;

  qpc_pin_sync #(.W(3)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .pin_in({PRESET_PIN, PHASE_B, PHASE_A}),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  qpc_step_decode u_decode (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .a_lvl(pin_level[0]),
    .b_lvl(pin_level[1]),
    .a_rise(pin_rise[0]),
    .a_fall(pin_fall[0]),
    .b_rise(pin_rise[1]),
    .b_fall(pin_fall[1]),
    .two_phase(phase_mode_ff),
    .edge_multiplication_factor(edge_multiplication_factor_ff),
    .dir_from_b(dir_src_ff),
    .down_sel(down_ff),
    .step(step),
    .up(step_up)
  );

  // Requests act on their rising edge, as a program-driven strobe would.
  always_comb begin
    nxt_cfg_req_d = CLK_EN ? COUNTER_CONFIGURE_REQUEST : cfg_req_d_ff;
    nxt_rd_req_d = CLK_EN ? COUNTER_READ_REQUEST : rd_req_d_ff;
    nxt_pre_req_d = CLK_EN ? COUNTER_PRESET_REQUEST : pre_req_d_ff;
    cfg_edge = CLK_EN & COUNTER_CONFIGURE_REQUEST & ~cfg_req_d_ff;
    rd_edge = CLK_EN & COUNTER_READ_REQUEST & ~rd_req_d_ff;
    pre_edge = CLK_EN & COUNTER_PRESET_REQUEST & ~pre_req_d_ff;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_req_d_ff <= 1'b0;
      rd_req_d_ff <= 1'b0;
      pre_req_d_ff <= 1'b0;
    end else begin
      cfg_req_d_ff <= nxt_cfg_req_d;
      rd_req_d_ff <= nxt_rd_req_d;
      pre_req_d_ff <= nxt_pre_req_d;
    end
  end

  // A rejected configuration leaves every setting as it was.
  always_comb begin
    edge_multiplication_factor_dec = QPC_X1;
    edge_multiplication_factor_ok = 1'b1;
    case (EDGE_MULTIPLICATION_FACTOR)                        // [R2]
      `QPC_EDGE_MULTIPLICATION_FACTOR_ONE: edge_multiplication_factor_dec = QPC_X1;
      `QPC_EDGE_MULTIPLICATION_FACTOR_TWO: edge_multiplication_factor_dec = QPC_X2;
      `QPC_EDGE_MULTIPLICATION_FACTOR_FOUR: edge_multiplication_factor_dec = QPC_X4;
      default: edge_multiplication_factor_ok = ~PHASE_MODE_SELECT;                 // [R8]
    endcase
    cfg_accept = cfg_edge & edge_multiplication_factor_ok;
    nxt_phase_mode = phase_mode_ff;
    nxt_edge_multiplication_factor = edge_multiplication_factor_ff;
    nxt_dir_src = dir_src_ff;
    nxt_down = down_ff;
    nxt_enable = enable_ff;
    nxt_pre_src = pre_src_ff;
    if (cfg_accept) begin
      nxt_phase_mode = PHASE_MODE_SELECT;                    // [R1]
      nxt_edge_multiplication_factor = PHASE_MODE_SELECT ? edge_multiplication_factor_dec : edge_multiplication_factor_ff;
      nxt_dir_src = DIR_SOURCE_SELECT;                       // [R3]
      nxt_down = DOWN_SELECT;                                // [R5]
      nxt_enable = COUNTER_ENABLE_BIT;                       // [R6]
      nxt_pre_src = PRESET_SOURCE_SELECT;                    // [R7]
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_mode_ff <= 1'b0;
      edge_multiplication_factor_ff <= QPC_X1;
      dir_src_ff <= 1'b0;
      down_ff <= 1'b0;
      enable_ff <= 1'b0;
      pre_src_ff <= 1'b0;
    end else begin
      phase_mode_ff <= nxt_phase_mode;
      edge_multiplication_factor_ff <= nxt_edge_multiplication_factor;
      dir_src_ff <= nxt_dir_src;
      down_ff <= nxt_down;
      enable_ff <= nxt_enable;
      pre_src_ff <= nxt_pre_src;
    end
  end

  // A preset takes the cycle over from any count step that lands with it.
  always_comb begin
    preset_value_in_range = (PRESET_VALUE <= `QPC_PRESET_VALUE_LIMIT);
    prog_load = pre_edge & enable_ff & ~pre_src_ff & preset_value_in_range;  // [R14] [R17]
    ext_load = CLK_EN & pin_rise[2] & enable_ff & pre_src_ff;        // [R15] [R17]
    wrap_up = step & step_up & (count_ff == `QPC_CNT_MAX);
    nxt_preset = preset_ff;
    if (pre_edge && preset_value_in_range) begin
      nxt_preset = PRESET_VALUE[`QPC_CNT_W-1:0];
    end
    nxt_count = count_ff;
    nxt_carry = carry_ff;
    if (cfg_accept && CARRY_CLEAR) begin
      nxt_carry = 1'b0;                                      // [R4]
    end
    if (!CLK_EN) begin
      nxt_count = count_ff;
      nxt_carry = carry_ff;
    end else if (!enable_ff) begin
      nxt_count = `QPC_CNT_RST;                              // [R10]
    end else if (prog_load) begin
      nxt_count = PRESET_VALUE[`QPC_CNT_W-1:0];              // [R14]
      nxt_carry = 1'b0;                                      // [R16]
    end else if (ext_load) begin
      nxt_count = preset_ff;                                 // [R15]
      nxt_carry = 1'b0;                                      // [R16]
    end else if (step) begin                                 // [R6]
      nxt_count = step_up ? count_ff + 1'b1 : count_ff - 1'b1;
      if (wrap_up) begin
        nxt_carry = 1'b1;                                    // [R23]
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      count_ff <= `QPC_CNT_RST;
      carry_ff <= 1'b0;
      preset_ff <= `QPC_CNT_RST;
    end else begin
      count_ff <= nxt_count;
      carry_ff <= nxt_carry;
      preset_ff <= nxt_preset;
    end
  end

  // Done pulses for one cycle while CLK_EN is high and holds while it is low; status holds until the next request.
  always_comb begin
    nxt_cfg_done = 1'b0;
    nxt_cfg_stat = cfg_stat_ff;
    nxt_rd_done = 1'b0;
    nxt_rd_stat = rd_stat_ff;
    nxt_rd_count = rd_count_ff;
    nxt_rd_carry = rd_carry_ff;
    nxt_pre_done = 1'b0;
    nxt_pre_stat = pre_stat_ff;
    if (cfg_edge) begin
      nxt_cfg_done = edge_multiplication_factor_ok;                                // [R18]
      nxt_cfg_stat = edge_multiplication_factor_ok ? `QPC_STAT_OK : `QPC_STAT_EDGE_MULTIPLICATION_FACTOR;  // [R21]
    end
    if (rd_edge) begin
      nxt_rd_done = 1'b1;                                    // [R18]
      nxt_rd_stat = `QPC_STAT_OK;
      nxt_rd_count = count_ff;                               // [R11]
      nxt_rd_carry = carry_ff;                               // [R12]
    end
    if (pre_edge) begin
      if (!enable_ff) begin
        nxt_pre_stat = `QPC_STAT_DISABLED;                   // [R22]
      end else if (!preset_value_in_range) begin
        nxt_pre_stat = `QPC_STAT_RANGE;
      end else begin
        nxt_pre_done = 1'b1;                                 // [R18]
        nxt_pre_stat = `QPC_STAT_OK;
      end
    end
    if (!CLK_EN) begin
      nxt_cfg_done = cfg_done_ff;
      nxt_rd_done = rd_done_ff;
      nxt_pre_done = pre_done_ff;
    end
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_done_ff <= 1'b0;
      cfg_stat_ff <= `QPC_STAT_OK;
      rd_done_ff <= 1'b0;
      rd_stat_ff <= `QPC_STAT_OK;
      rd_count_ff <= `QPC_CNT_RST;
      rd_carry_ff <= 1'b0;
      pre_done_ff <= 1'b0;
      pre_stat_ff <= `QPC_STAT_OK;
    end else begin
      cfg_done_ff <= nxt_cfg_done;
      cfg_stat_ff <= nxt_cfg_stat;
      rd_done_ff <= nxt_rd_done;
      rd_stat_ff <= nxt_rd_stat;
      rd_count_ff <= nxt_rd_count;
      rd_carry_ff <= nxt_rd_carry;
      pre_done_ff <= nxt_pre_done;
      pre_stat_ff <= nxt_pre_stat;
    end
  end

  assign CFG_DONE = cfg_done_ff;
  assign CFG_STAT = cfg_stat_ff;
  assign RD_DONE = rd_done_ff;
  assign RD_STAT = rd_stat_ff;
  assign CURRENT_COUNT = rd_count_ff;
  assign CARRY_FLAG = rd_carry_ff;
  assign PRE_DONE = pre_done_ff;
  assign PRE_STAT = pre_stat_ff;

  disabled_zero_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R10]
    (CLK_EN && !enable_ff) |=> (count_ff == `QPC_CNT_RST))
    else $error("count not cleared while disabled");
  edge_multiplication_factor_reject_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R21]
    (cfg_edge && PHASE_MODE_SELECT && !edge_multiplication_factor_ok) |=> (CFG_STAT == `QPC_STAT_EDGE_MULTIPLICATION_FACTOR) && !CFG_DONE
      && (edge_multiplication_factor_ff == $past(edge_multiplication_factor_ff)))
    else $error("bad factor not rejected");
  preset_refuse_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R22]
    (pre_edge && !enable_ff) |=> (PRE_STAT == `QPC_STAT_DISABLED) && !PRE_DONE)
    else $error("disabled preset not refused");
  prog_load_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R14]
    prog_load |=> (count_ff == $past(PRESET_VALUE[23:0])) && PRE_DONE)
    else $error("program preset not loaded");
  ext_load_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R15]
    (CLK_EN && pin_rise[2] && enable_ff && pre_src_ff) |=> (count_ff == $past(preset_ff)))
    else $error("external preset not loaded");
  preset_carry_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R16]
    (prog_load || ext_load) |=> !carry_ff)
    else $error("carry not off after preset");
  wrap_carry_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R23]
    (CLK_EN && enable_ff && !prog_load && !ext_load && wrap_up)
      |=> (count_ff == `QPC_CNT_RST) && carry_ff)
    else $error("wrap did not set carry");
  down_step_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R5]
    (CLK_EN && enable_ff && !prog_load && !ext_load && step && !step_up)
      |=> (count_ff == $past(count_ff) - 24'h000001))
    else $error("down step wrong");
  read_snap_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R11] [R12]
    rd_edge |=> RD_DONE && (CURRENT_COUNT == $past(count_ff)) && (CARRY_FLAG == $past(carry_ff)))
    else $error("read did not return state");
  carry_clear_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)  // [R4]
    (cfg_accept && CARRY_CLEAR && !wrap_up) |=> !carry_ff)
    else $error("carry not cleared");
endmodule

// File: qpc_pulse_gen.sv
/*
  Behavioural pulse generator standing in front of the counter's pins.
  Assumes the bench calls its tasks at a falling clock edge; every task
  also returns at a falling edge so requests can follow at once.
*/
`timescale 1ns/1ps

module qpc_pulse_gen (
  // Clock
  input wire logic clk,
  // Pins
  output logic a,
  output logic b,
  output logic pre
);
  initial begin
    a = 1'b0;
    b = 1'b0;
    pre = 1'b0;
  end

  // Each level is held for several clocks so the two-stage synchroniser sees it.
  task automatic hold;
    repeat (4) @(negedge clk);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      a = 1'b1;
      hold();
      a = 1'b0;
      hold();
    end
  endtask

  task automatic set_b(input logic v);
    b = v;
    hold();
  endtask

  // Up order lets A lead B; down order lets B lead A.
  task automatic quad(input int n, input logic up);
    repeat (n) begin
      if (up) begin
        a = 1'b1;
        hold();
        b = 1'b1;
        hold();
        a = 1'b0;
        hold();
        b = 1'b0;
        hold();
      end else begin
        b = 1'b1;
        hold();
        a = 1'b1;
        hold();
        b = 1'b0;
        hold();
        a = 1'b0;
        hold();
      end
    end
  endtask

  task automatic preset_pulse;
    pre = 1'b1;
    hold();
    pre = 1'b0;
    hold();
  endtask
endmodule

// File: quadrature_pulse_counter_24bit_tb_top.sv
/*
  Self-checking bench of the 24-bit pulse counter. Drivers note expected
  answers in a queue; a watcher compares them when a done pulse appears.
  Assumes qpc_pkg, qpc_counter_top and qpc_pulse_gen are compiled first.
*/
`timescale 1ns/1ps

module quadrature_pulse_counter_24bit_tb_top;
  import qpc_pkg::*;
  typedef struct {logic [1:0] kind; qpc_stat_t stat; qpc_count_t cnt; logic cy;} qpc_note_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, pa, pb, pp;
  logic cfg_req = 1'b0, phase_mode_select = 1'b0, dsrc = 1'b0, cyr = 1'b0, dn = 1'b0, en = 1'b0, psrc = 1'b0;
  logic rd_req = 1'b0, pre_req = 1'b0, cfg_done, rd_done, pre_done, cy;
  qpc_edge_multiplication_factor_code_t edge_multiplication_factor = 8'h01;
  qpc_stat_t cfg_stat, rd_stat, pre_stat;
  qpc_count_t cnt;
  logic [31:0] pval = 32'h0;
  logic [23:0] v;
  qpc_note_t q[$];
  int err_total = 0, n_tests = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  qpc_pulse_gen gen (.clk(clk), .a(pa), .b(pb), .pre(pp));

  qpc_counter_top dut (
    .CLK_SYS(clk), .SYS_RST(rst), .CLK_EN(ce),
    .PHASE_A(pa), .PHASE_B(pb), .PRESET_PIN(pp),
    .COUNTER_CONFIGURE_REQUEST(cfg_req), .PHASE_MODE_SELECT(phase_mode_select),
    .EDGE_MULTIPLICATION_FACTOR(edge_multiplication_factor), .DIR_SOURCE_SELECT(dsrc), .CARRY_CLEAR(cyr),
    .DOWN_SELECT(dn), .COUNTER_ENABLE_BIT(en), .PRESET_SOURCE_SELECT(psrc),
    .CFG_DONE(cfg_done), .CFG_STAT(cfg_stat),
    .COUNTER_READ_REQUEST(rd_req), .RD_DONE(rd_done), .RD_STAT(rd_stat),
    .CURRENT_COUNT(cnt), .CARRY_FLAG(cy),
    .COUNTER_PRESET_REQUEST(pre_req), .PRESET_VALUE(pval),
    .PRE_DONE(pre_done), .PRE_STAT(pre_stat)
  );

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Done pulses last one cycle, so the falling edge after them is the place to look.
  always @(negedge clk) begin
    qpc_note_t n;
    if (cfg_done === 1'b1 || rd_done === 1'b1 || pre_done === 1'b1) begin
      if (q.size() == 0) begin
        check("unexpected done", 1, 0);
      end else begin
        n = q.pop_front();
        check("done kind", {rd_done, pre_done}, {n.kind == 2'd1, n.kind == 2'd2});
        if (n.kind == 2'd1) begin
          check("read status", rd_stat, n.stat);
          check("count", cnt, n.cnt);
          check("carry", cy, n.cy);
        end else begin
          check("status", n.kind == 2'd0 ? cfg_stat : pre_stat, n.stat);
        end
      end
    end
  end

  task automatic strobe(input int k);
    @(negedge clk);
    if (k == 0) cfg_req = 1'b1;
    else if (k == 1) rd_req = 1'b1;
    else pre_req = 1'b1;
    @(negedge clk);
    cfg_req = 1'b0;
    rd_req = 1'b0;
    pre_req = 1'b0;
    repeat (3) @(negedge clk);
    check("answers pending", q.size(), 0);
  endtask

  task automatic cfg(input logic p, input logic [7:0] m, input logic ds, input logic c,
                     input logic d, input logic e, input logic s, input logic [7:0] st);
    {phase_mode_select, edge_multiplication_factor, dsrc, cyr, dn, en, psrc} = {p, m, ds, c, d, e, s};
    if (st == 8'h00) q.push_back('{2'd0, 8'h00, 24'h0, 1'b0});
    strobe(0);
    check("config status", cfg_stat, st);
  endtask

  task automatic rd(input logic [23:0] c, input logic y);
    repeat (8) @(negedge clk);
    q.push_back('{2'd1, 8'h00, c, y});
    strobe(1);
  endtask

  task automatic pre(input logic [31:0] val, input logic [7:0] st);
    pval = val;
    if (st == 8'h00) q.push_back('{2'd2, 8'h00, 24'h0, 1'b0});
    strobe(2);
    check("preset status", pre_stat, st);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    void'($urandom(11689));
    rd(24'h0, 1'b0);
    cfg(0, 8'h01, 0, 0, 0, 1, 0, 8'h00);
    gen.pulses(5);
    rd(24'h5, 1'b0);
    cfg(0, 8'h01, 0, 0, 1, 1, 0, 8'h00);
    gen.pulses(2);
    rd(24'h3, 1'b0);
    cfg(0, 8'h01, 1, 0, 1, 1, 0, 8'h00);
    gen.set_b(1'b1);
    gen.pulses(2);
    rd(24'h5, 1'b0);
    gen.set_b(1'b0);
    gen.pulses(1);
    rd(24'h4, 1'b0);
    cfg(0, 8'h01, 0, 0, 0, 1, 0, 8'h00);
    pre(32'h00ffffff, 8'h00);
    gen.pulses(1);
    rd(24'h0, 1'b1);
    v = 24'($urandom());
    pre({8'h00, v}, 8'h00);
    rd(v, 1'b0);
    pre(32'h00ffffff, 8'h00);
    gen.pulses(1);
    cfg(0, 8'h01, 0, 1, 0, 1, 0, 8'h00);
    rd(24'h0, 1'b0);
    pre(32'h01000000, 8'h03);
    for (int f = 1; f <= 4; f = f * 2) begin
      cfg(1, 8'(f), 1'($urandom()), 0, 1'($urandom()), 1, 0, 8'h00);
      pre(32'd100, 8'h00);
      gen.quad(3, 1'b1);
      gen.quad(1, 1'b0);
      rd(24'(100 + 2 * f), 1'b0);
    end
    cfg(1, 8'h03, 0, 0, 0, 1, 0, 8'h02);
    cfg(0, 8'($urandom()), 0, 0, 0, 1, 0, 8'h00);
    pre(32'h0, 8'h00);
    gen.pulses(2);
    rd(24'h2, 1'b0);
    // Pulses while the clock enable is low must leave no trace.
    ce = 1'b0;
    gen.pulses(1 + ($urandom() % 3));
    ce = 1'b1;
    rd(24'h2, 1'b0);
    cfg(1'($urandom()), 8'h01, 0, 1'($urandom()), 0, 0, 1'($urandom()), 8'h00);
    gen.pulses(2);
    rd(24'h0, 1'b0);
    pre(32'h7, 8'h04);
    rd(24'h0, 1'b0);
    cfg(0, 8'h01, 0, 0, 0, 1, 1, 8'h00);
    v = 24'($urandom());
    pre({8'h00, v}, 8'h00);
    rd(24'h0, 1'b0);
    gen.preset_pulse();
    rd(v, 1'b0);
    stop_test();
  end
endmodule
